/* File: include/esl_pkg.sv */
package esl_pkg;
  // Position word layout
  localparam int unsigned SINGLE_BITS = 16;
  localparam int unsigned MULTI_BITS = 14;
  localparam int unsigned POS_BITS = SINGLE_BITS + MULTI_BITS;
  localparam int unsigned SINGLE_LSB = 0;
  localparam int unsigned MULTI_LSB = SINGLE_BITS;
  // Network address width and factory value
  localparam int unsigned ADDR_BITS = 32;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  // Clock rate
  localparam int unsigned MCLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = MCLK_HZ / 1000;
  // Blink timing: half period of each blink rate, and least hold of error pattern
  localparam int unsigned IDENT_HALF_MS = 250;
  localparam int unsigned ERR_HALF_MS = 1000;
  localparam int unsigned ERR_HOLD_MS = 3000;
  localparam int unsigned IDENT_HALF_CYC = IDENT_HALF_MS * CYC_PER_MS;
  localparam int unsigned ERR_HALF_CYC = ERR_HALF_MS * CYC_PER_MS;
  localparam int unsigned ERR_HOLD_CYC = ERR_HOLD_MS * CYC_PER_MS;
  localparam int unsigned CNT_BITS = 32;
  // Status indicator patterns
  typedef enum logic [2:0] {
    ST_NOEXCH = 3'b001,
    ST_PARERR = 3'b010,
    ST_NORMAL = 3'b100
  } esl_stat_t;
endpackage

/* File: logic/esl_blink_gen.sv */
`timescale 1ns/1ps
module esl_blink_gen #(
  parameter int unsigned HALF_CYC = esl_pkg::IDENT_HALF_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  output logic phase
);
  logic [esl_pkg::CNT_BITS-1:0] cnt_q;
  logic phase_q;
  wire logic atEnd = (cnt_q == esl_pkg::CNT_BITS'(HALF_CYC - 1));

  // Restart on the lit phase whenever idle, so a blink always opens lit
  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      cnt_q <= '0;
      phase_q <= 1'b1;
    end else if (atEnd) begin
      cnt_q <= '0;
      phase_q <= ~phase_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign phase = phase_q;

  toggle_at_end_a: assert property (@(posedge mclk) disable iff (reset)
    run && $past(run) && (phase_q != $past(phase_q)) |-> $past(atEnd))
    else $error("Blink phase changed before its half period ended");
endmodule

/* File: logic/esl_status_led.sv */
`timescale 1ns/1ps
// Functional notes
// - Single-turn position is sixteen bits, 65536 steps per revolution.
// - Multiturn variant adds a fourteen-bit revolution count above single-turn.
// - Network address reads all zero until configuration assigns one.
// - Port one activity LED lit while frames move on port one.
// - Port one link LED lit steadily while port one has link.
// - Identification request with link blinks port one link LED at 2 Hz.
// - Port two link LED lit steadily while port two has link.
// - No frames and no cyclic exchange: green and red status LEDs both steadily on.
// - Parameter mismatch: green on, red blinks 0.5 Hz, at least 3 s.
// - Normal cyclic exchange: green status on, red status off.
module esl_status_led #(
  parameter int unsigned IDENT_HALF_CYC = esl_pkg::IDENT_HALF_CYC,
  parameter int unsigned ERR_HALF_CYC = esl_pkg::ERR_HALF_CYC,
  parameter int unsigned ERR_HOLD_CYC = esl_pkg::ERR_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic port1ActPin,
  input wire logic port1LinkPin,
  input wire logic port2ActPin,
  input wire logic port2LinkPin,
  input wire logic identifyReq,
  input wire logic framesOk,
  input wire logic cyclicExchange,
  input wire logic multiturnVariant,
  input wire logic [esl_pkg::SINGLE_BITS-1:0] singleTurn,
  input wire logic [esl_pkg::MULTI_BITS-1:0] multiTurn,
  input wire logic netAddrWrite,
  input wire logic [esl_pkg::ADDR_BITS-1:0] netAddrIn,
  output logic [esl_pkg::POS_BITS-1:0] position,
  output logic [esl_pkg::ADDR_BITS-1:0] netAddr,
  output logic ledAct1,
  output logic ledLink1,
  output logic ledAct2,
  output logic ledLink2,
  output logic ledStatGreen,
  output logic ledStatRed
);
  // Pin synchronisers: stage one feeds only stage two
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  wire logic [3:0] pinRaw = {port2LinkPin, port2ActPin, port1LinkPin, port1ActPin};
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  wire logic act1S = pinSync_q[0];
  wire logic link1S = pinSync_q[1];
  wire logic act2S = pinSync_q[2];
  wire logic link2S = pinSync_q[3];

  // Position word: revolutions only in the multiturn build, else zero
  logic [esl_pkg::POS_BITS-1:0] position_q;
  wire logic [esl_pkg::MULTI_BITS-1:0] turnsSel = multiturnVariant ? multiTurn : '0;
  wire logic [esl_pkg::POS_BITS-1:0] position_d = {turnsSel, singleTurn};
  always_ff @(posedge mclk) begin
    if (reset) begin
      position_q <= '0;
    end else begin
      position_q <= position_d;
    end
  end

  // Network address, factory value until configured
  logic [esl_pkg::ADDR_BITS-1:0] netAddr_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      netAddr_q <= esl_pkg::ADDR_RESET;
    end else if (netAddrWrite) begin
      netAddr_q <= netAddrIn;
    end
  end

  // Blink sources; each restarts lit when its pattern starts
  logic identPhase;
  logic errPhase;
  wire logic identBlink = identifyReq && link1S;
  esl_blink_gen #(.HALF_CYC(IDENT_HALF_CYC)) identBlinkGen (
    .mclk(mclk),
    .reset(reset),
    .run(identBlink),
    .phase(identPhase)
  );

  // Status selection with fixed priority
  esl_pkg::esl_stat_t stat_q;
  esl_pkg::esl_stat_t stat_d;
  logic [esl_pkg::CNT_BITS-1:0] hold_q;
  logic [esl_pkg::CNT_BITS-1:0] hold_d;
  wire logic noExch = !framesOk && !cyclicExchange;
  wire logic holdBusy = (hold_q != '0);
  wire logic errRun = (stat_q == esl_pkg::ST_PARERR);

  esl_blink_gen #(.HALF_CYC(ERR_HALF_CYC)) errBlinkGen (
    .mclk(mclk),
    .reset(reset),
    .run(errRun),
    .phase(errPhase)
  );

  // Error pattern holds its least time; only a lost exchange may cut it short
  always_comb begin
    stat_d = stat_q;
    hold_d = holdBusy ? hold_q - 1'b1 : hold_q;
    if (noExch) begin
      stat_d = esl_pkg::ST_NOEXCH;
      hold_d = '0;
    end else if (!cyclicExchange || (stat_q == esl_pkg::ST_PARERR && holdBusy)) begin
      stat_d = esl_pkg::ST_PARERR;
      if (stat_q != esl_pkg::ST_PARERR) begin
        hold_d = esl_pkg::CNT_BITS'(ERR_HOLD_CYC - 1);
      end
    end else begin
      stat_d = esl_pkg::ST_NORMAL;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stat_q <= esl_pkg::ST_NOEXCH;
      hold_q <= '0;
    end else begin
      stat_q <= stat_d;
      hold_q <= hold_d;
    end
  end

  // LED drive decode
  logic ledAct1_q;
  logic ledLink1_q;
  logic ledAct2_q;
  logic ledLink2_q;
  logic ledGreen_q;
  logic ledRed_q;
  wire logic link1Drive = identBlink ? identPhase : link1S;
  logic greenDrive;
  logic redDrive;
  always_comb begin
    greenDrive = 1'b1;
    redDrive = 1'b0;
    unique case (stat_q)
      esl_pkg::ST_NOEXCH: begin
        redDrive = 1'b1;
      end
      esl_pkg::ST_PARERR: begin
        redDrive = errPhase;
      end
      esl_pkg::ST_NORMAL: begin
        redDrive = 1'b0;
      end
      default: begin
        redDrive = 1'b1;
      end
    endcase
  end

  // Activity follows the PHY indication as delivered; no extra stretch
  always_ff @(posedge mclk) begin
    if (reset) begin
      ledAct1_q <= 1'b0;
      ledLink1_q <= 1'b0;
      ledAct2_q <= 1'b0;
      ledLink2_q <= 1'b0;
      ledGreen_q <= 1'b0;
      ledRed_q <= 1'b0;
    end else begin
      ledAct1_q <= act1S;
      ledLink1_q <= link1Drive;
      ledAct2_q <= act2S;
      ledLink2_q <= link2S;
      ledGreen_q <= greenDrive;
      ledRed_q <= redDrive;
    end
  end

  assign position = position_q;
  assign netAddr = netAddr_q;
  assign ledAct1 = ledAct1_q;
  assign ledLink1 = ledLink1_q;
  assign ledAct2 = ledAct2_q;
  assign ledLink2 = ledLink2_q;
  assign ledStatGreen = ledGreen_q;
  assign ledStatRed = ledRed_q;

  pos_layout_a: assert property (@(posedge mclk) disable iff (reset)
    $past(!multiturnVariant) |-> position[esl_pkg::POS_BITS-1:esl_pkg::MULTI_LSB] == '0)
    else $error("Revolution field not zero in single-turn build");

  single_turn_a: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> position[esl_pkg::SINGLE_BITS-1:0] == $past(singleTurn))
    else $error("Single-turn field does not follow the sensor");

  addr_factory_a: assert property (@(posedge mclk)
    reset ##1 (!netAddrWrite)[*3] |=> netAddr == '0)
    else $error("Address not zero before assignment");

  act1_follow_a: assert property (@(posedge mclk) disable iff (reset)
    port1ActPin [*4] |-> ##[0:1] ledAct1)
    else $error("Port one activity LED not lit");

  link1_off_a: assert property (@(posedge mclk) disable iff (reset)
    (!port1LinkPin) [*5] |-> !ledLink1)
    else $error("Port one link LED lit without link");

  link1_steady_a: assert property (@(posedge mclk) disable iff (reset)
    (port1LinkPin && !identifyReq) [*5] |-> ledLink1)
    else $error("Port one link LED not steady");

  link2_steady_a: assert property (@(posedge mclk) disable iff (reset)
    port2LinkPin [*4] |-> ##[0:1] ledLink2)
    else $error("Port two link LED not lit");

  act2_follow_a: assert property (@(posedge mclk) disable iff (reset)
    (!port2ActPin) [*5] |-> !ledAct2)
    else $error("Port two activity LED lit while idle");

  noexch_both_a: assert property (@(posedge mclk) disable iff (reset)
    noExch |=> stat_q == esl_pkg::ST_NOEXCH ##1 (ledStatGreen && ledStatRed))
    else $error("No-exchange pattern not shown");

  parerr_hold_a: assert property (@(posedge mclk) disable iff (reset)
    stat_q == esl_pkg::ST_NORMAL && $past(stat_q) == esl_pkg::ST_PARERR |-> $past(hold_q) == '0)
    else $error("Error pattern left before its least time");

  normal_red_off_a: assert property (@(posedge mclk) disable iff (reset)
    stat_q == esl_pkg::ST_NORMAL |=> ledStatGreen && !ledStatRed)
    else $error("Normal pattern wrong");

  one_pattern_a: assert property (@(posedge mclk) disable iff (reset)
    $onehot(stat_q) and (cyclicExchange && !framesOk |=> stat_q != esl_pkg::ST_NOEXCH))
    else $error("Status pattern priority broken");
endmodule

/* File: sim/esl_net_peer.sv */
`timescale 1ns/1ps
// Far-side network peer: two PHY ports plus the controller
module esl_net_peer (
  input wire logic linkUp1,
  input wire logic linkUp2,
  input wire logic busy1,
  input wire logic busy2,
  input wire logic [1:0] ctrlMode,
  input wire logic identOn,
  output logic port1ActPin,
  output logic port1LinkPin,
  output logic port2ActPin,
  output logic port2LinkPin,
  output logic framesOk,
  output logic cyclicExchange,
  output logic identifyReq
);
  // A PHY shows traffic only on a port that has link
  assign port1ActPin = busy1 & linkUp1;
  assign port2ActPin = busy2 & linkUp2;
  assign port1LinkPin = linkUp1;
  assign port2LinkPin = linkUp2;
  // Mode 0 absent, 1 wrong configuration, 2 cyclic exchange, 3 cyclic without frame flag
  assign framesOk = (ctrlMode == 2'h1) || (ctrlMode == 2'h2);
  assign cyclicExchange = ctrlMode[1];
  // Identification call reaches us only over a live link
  assign identifyReq = identOn & linkUp1;
endmodule

/* File: sim/esl_status_led_test.sv */
`timescale 1ns/1ps
module esl_status_led_test;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic linkUp1, linkUp2, busy1, busy2, identOn, multiturnVariant, netAddrWrite;
  logic [1:0] ctrlMode;
  logic [15:0] singleTurn;
  logic [13:0] multiTurn;
  logic [31:0] netAddrIn;
  wire logic a1, l1, a2, l2, fOk, cyc, idReq;
  logic [29:0] position;
  logic [31:0] netAddr;
  logic ledAct1, ledLink1, ledAct2, ledLink2, ledStatGreen, ledStatRed;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  // Short blink counts keep the run small
  esl_status_led #(.IDENT_HALF_CYC(4), .ERR_HALF_CYC(8), .ERR_HOLD_CYC(40)) dut (.mclk(mclk), .reset(reset),
    .port1ActPin(a1), .port1LinkPin(l1), .port2ActPin(a2), .port2LinkPin(l2), .identifyReq(idReq),
    .framesOk(fOk), .cyclicExchange(cyc), .multiturnVariant(multiturnVariant), .singleTurn(singleTurn),
    .multiTurn(multiTurn), .netAddrWrite(netAddrWrite), .netAddrIn(netAddrIn), .position(position),
    .netAddr(netAddr), .ledAct1(ledAct1), .ledLink1(ledLink1), .ledAct2(ledAct2), .ledLink2(ledLink2),
    .ledStatGreen(ledStatGreen), .ledStatRed(ledStatRed));
  esl_net_peer peer (.linkUp1(linkUp1), .linkUp2(linkUp2), .busy1(busy1), .busy2(busy2),
    .ctrlMode(ctrlMode), .identOn(identOn), .port1ActPin(a1), .port1LinkPin(l1), .port2ActPin(a2),
    .port2LinkPin(l2), .framesOk(fOk), .cyclicExchange(cyc), .identifyReq(idReq));
  always #50 mclk = ~mclk;
  // Hang guard, well above the roughly 130 cycles the tests need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic cur(input logic sel);
    return sel ? ledLink1 : ledStatRed;
  endfunction
  // Waits for an edge of the chosen LED, then times the next run
  task automatic half(input string what, input logic sel, input int exp);
    logic v;
    int n;
    v = cur(sel);
    for (n = 0; cur(sel) === v && n < 40; n++) tick(1);
    v = cur(sel);
    for (n = 0; cur(sel) === v && n < 40; n++) tick(1);
    chk(what, exp, n);
  endtask
  task automatic t_pos();
    logic [15:0] st[3] = '{16'hffff, 16'h0001, 16'hffff};
    logic [13:0] mt[3] = '{14'h3fff, 14'h2000, 14'h3fff};
    logic mv[3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      singleTurn = st[i];
      multiTurn = mt[i];
      multiturnVariant = mv[i];
      tick(1);
      chk("position", {2'h0, mv[i] ? mt[i] : 14'h0, st[i]}, position);
    end
    $display("done position");
  endtask
  task automatic t_addr();
    chk("netAddr", 32'h0, netAddr);
    netAddrWrite = 1'b1;
    netAddrIn = 32'hc0a80a05;
    tick(1);
    netAddrIn = 32'h0a000002;
    tick(1);
    netAddrWrite = 1'b0;
    chk("netAddr", 32'h0a000002, netAddr);
    // Mid-run reset must bring back the factory address
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(2);
    chk("netAddr after reset", 32'h0, netAddr);
    chk("red after reset", 1, ledStatRed);
    $display("done address");
  endtask
  task automatic t_ports();
    linkUp1 = 1'b1;
    linkUp2 = 1'b1;
    tick(2);
    chk("ledLink1 early", 0, ledLink1);
    tick(1);
    chk("ledLink1", 1, ledLink1);
    chk("ledLink2", 1, ledLink2);
    busy1 = 1'b1;
    busy2 = 1'b1;
    tick(2);
    chk("ledAct1 early", 0, ledAct1);
    tick(1);
    chk("ledAct1", 1, ledAct1);
    chk("ledAct2", 1, ledAct2);
    busy1 = 1'b0;
    tick(3);
    chk("ledAct1 off", 0, ledAct1);
    chk("ledAct2 held", 1, ledAct2);
    $display("done ports");
  endtask
  task automatic t_ident();
    identOn = 1'b1;
    half("ident half", 1'b1, 4);
    half("ident half", 1'b1, 4);
    identOn = 1'b0;
    tick(4);
    chk("ledLink1 steady", 1, ledLink1);
    $display("done identify");
  endtask
  task automatic t_status();
    chk("green noexch", 1, ledStatGreen);
    chk("red noexch", 1, ledStatRed);
    ctrlMode = 2'h1;
    tick(2);
    chk("red parerr", 1, ledStatRed);
    ctrlMode = 2'h2;
    half("error half", 1'b0, 8);
    tick(19);
    chk("red hold", 1, ledStatRed);
    tick(13);
    for (int i = 0; i < 10; i++) begin
      chk("red normal", 0, ledStatRed);
      chk("green normal", 1, ledStatGreen);
      tick(1);
    end
    // Cyclic exchange without the frame flag still counts as normal
    ctrlMode = 2'h3;
    tick(3);
    chk("red cyclic only", 0, ledStatRed);
    ctrlMode = 2'h1;
    tick(4);
    ctrlMode = 2'h0;
    tick(2);
    for (int i = 0; i < 12; i++) begin
      chk("red preempt", 1, ledStatRed);
      tick(1);
    end
    $display("done status");
  endtask
  initial begin
    {linkUp1, linkUp2, busy1, busy2, identOn, multiturnVariant, netAddrWrite} = '0;
    ctrlMode = 2'h0;
    singleTurn = 16'h0;
    multiTurn = 14'h0;
    netAddrIn = 32'h0;
    tick(6);
    reset = 1'b0;
    tick(3);
    t_status();
    t_addr();
    t_pos();
    t_ports();
    t_ident();
    end_sim();
  end
endmodule
